/* scg_clock_gen.sv */
`default_nettype none
module scg_clock_gen
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Register access
  input wire scg_pkg::scg_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  // Boot option and neighbours
  input wire logic [7:0] i_option_byte,
  input wire logic i_watchdog_run,
  input wire logic i_stop_exit,
  // Crystal side
  input wire logic i_crystal_tick,
  output logic o_crystal_run,
  output logic o_crystal_gain_high,
  output logic o_ext_clk_enable,
  output logic o_xpin_input_mode,
  // Internal oscillators
  output logic o_fast_osc_run,
  output logic [2:0] o_fast_osc_code,
  output logic o_slow_osc_run,
  // Main clock control
  output logic o_main_src_sel,
  output logic o_clk_hold,
  output logic o_cpu_reset_hold
);
  import scg_pkg::*;

  scg_state_t st_ff;
  scg_state_t nxt_st;
  logic [7:0] stab_status;
  logic stab_done;
  logic [2:0] stab_limit;
  logic xtal_ready;
  logic src_ready;
  logic wr_ok;
  logic [7:0] wd;
  logic [12:0] ast_cyc;

  // The CPU is held during reset processing, so writes then are dropped.
  assign wr_ok = i_sfr.wr && !st_ff.rst_hold;
  assign wd = i_sfr.wdata;

  // A full count after starting the crystal, the selected one after STOP.
  assign stab_limit = st_ff.after_stop ? st_ff.stab_sel : STAB_SEL_MAX;

  scg_stab_counter u_stab
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_run(st_ff.xtal_run),
    .i_restart(i_stop_exit),
    .i_tick(i_crystal_tick),
    .i_limit(stab_limit),
    .o_status(stab_status),
    .o_done(stab_done)
  );

  // An external clock is usable as soon as its input is enabled.
  assign xtal_ready = st_ff.ext_en || (st_ff.xtal_run && stab_done);

  // The slow oscillator is never a candidate here.
  assign src_ready = st_ff.src_req ? xtal_ready : st_ff.fast_run;

  always_comb
  begin
    nxt_st = st_ff;

    if (st_ff.rst_hold)
    begin
      if (!st_ff.boot_loaded)
      begin
        nxt_st.freq_code = i_option_byte[2:0];
        nxt_st.freq_pend = i_option_byte[2:0];
        nxt_st.boot_loaded = 1'b1;
      end
      if (st_ff.rst_cnt == HOCO_SETTLE_CYC)
      begin
        nxt_st.rst_hold = 1'b0;
      end
      else
      begin
        nxt_st.rst_cnt = st_ff.rst_cnt + 12'h001;
      end
    end

    // Frequency select writes that arrive during a retune are dropped; the
    // clock is held only in FS_WAIT, and other registers still take writes.
    case (st_ff.fstate)
      FS_IDLE:
      begin
        if (wr_ok && (i_sfr.addr == ADDR_FREQ_SEL) && freq_code_ok(wd[2:0]))
        begin
          nxt_st.freq_pend = wd[2:0];
          nxt_st.fstate = FS_OLD;
          nxt_st.fcnt = 2'h0;
        end
      end
      FS_OLD:
      begin
        nxt_st.fcnt = st_ff.fcnt + 2'h1;
        if (st_ff.fcnt == 2'(FREQ_OLD_CYC - 1))
        begin
          nxt_st.freq_code = st_ff.freq_pend;
          nxt_st.clk_hold = 1'b1;
          nxt_st.fstate = FS_WAIT;
          nxt_st.fcnt = 2'h0;
        end
      end
      FS_WAIT:
      begin
        nxt_st.fcnt = st_ff.fcnt + 2'h1;
        if (st_ff.fcnt == 2'(FREQ_WAIT_CYC - 1))
        begin
          nxt_st.clk_hold = 1'b0;
          nxt_st.fstate = FS_IDLE;
          nxt_st.fcnt = 2'h0;
        end
      end
      default:
      begin
        nxt_st.fstate = FS_IDLE;
      end
    endcase

    if (wr_ok)
    begin
      if (i_sfr.addr == ADDR_OSC_MODE)
      begin
        if (!st_ff.mode_locked)
        begin
          nxt_st.ext_sel = wd[BIT_EXT_SEL];
          nxt_st.osc_sel = wd[BIT_OSC_SEL];
          nxt_st.gain_high = wd[BIT_GAIN];
          nxt_st.mode_locked = 1'b1;
        end
      end
      else if (i_sfr.addr == ADDR_RUN_CTRL)
      begin
        nxt_st.xtal_stop = wd[BIT_XTAL_STOP];
        nxt_st.fast_run = !wd[BIT_FAST_STOP];
      end
      else if (i_sfr.addr == ADDR_STAB_SEL)
      begin
        nxt_st.stab_sel = wd[2:0];
      end
      else if (i_sfr.addr == ADDR_SPEED_MODE)
      begin
        nxt_st.itmr_clk = wd[BIT_ITMR_CLK];
      end
      else if (i_sfr.addr == ADDR_CLK_SEL)
      begin
        nxt_st.src_req = wd[BIT_SRC_SEL];
      end
    end

    // Mode decode: 0,0 input port; 0,1 crystal; 1,1 external clock.
    nxt_st.xtal_run = nxt_st.osc_sel && !nxt_st.ext_sel && !nxt_st.xtal_stop;
    nxt_st.ext_en = nxt_st.osc_sel && nxt_st.ext_sel && !nxt_st.xtal_stop;
    nxt_st.pin_input = !nxt_st.osc_sel;

    if (i_stop_exit)
    begin
      nxt_st.after_stop = 1'b1;
    end
    else if (!st_ff.xtal_run)
    begin
      nxt_st.after_stop = 1'b0;
    end

    nxt_st.slow_run = i_watchdog_run || st_ff.itmr_clk;

    // The status bit only moves after the new source has been seen
    // running for a few cycles, so the clock tree never sees a runt.
    case (st_ff.sstate)
      SS_IDLE:
      begin
        if (st_ff.src_req != st_ff.src_stat)
        begin
          nxt_st.sstate = SS_WAIT;
        end
      end
      SS_WAIT:
      begin
        if (st_ff.src_req == st_ff.src_stat)
        begin
          nxt_st.sstate = SS_IDLE;
        end
        else if (src_ready)
        begin
          nxt_st.sstate = SS_COUNT;
          nxt_st.scnt = 2'h0;
        end
      end
      SS_COUNT:
      begin
        if (st_ff.src_req == st_ff.src_stat)
        begin
          nxt_st.sstate = SS_IDLE;
        end
        else if (!src_ready)
        begin
          nxt_st.sstate = SS_WAIT;
        end
        else if (st_ff.scnt == 2'(SRC_SWITCH_CYC - 1))
        begin
          nxt_st.src_stat = st_ff.src_req;
          nxt_st.sstate = SS_IDLE;
        end
        else
        begin
          nxt_st.scnt = st_ff.scnt + 2'h1;
        end
      end
      default:
      begin
        nxt_st.sstate = SS_IDLE;
      end
    endcase

    nxt_st.rdata = 8'h00;
    if (i_sfr.rd)
    begin
      if (i_sfr.addr == ADDR_BOOT_OPT)
      begin
        nxt_st.rdata = i_option_byte;
      end
      else if (i_sfr.addr == ADDR_FREQ_SEL)
      begin
        nxt_st.rdata = {5'h00, st_ff.freq_pend};
      end
      else if (i_sfr.addr == ADDR_OSC_MODE)
      begin
        nxt_st.rdata = {st_ff.ext_sel, st_ff.osc_sel, 5'h00, st_ff.gain_high};
      end
      else if (i_sfr.addr == ADDR_RUN_CTRL)
      begin
        nxt_st.rdata = {st_ff.xtal_stop, 6'h00, !st_ff.fast_run};
      end
      else if (i_sfr.addr == ADDR_STAB_SEL)
      begin
        nxt_st.rdata = {5'h00, st_ff.stab_sel};
      end
      else if (i_sfr.addr == ADDR_STAB_STAT)
      begin
        nxt_st.rdata = stab_status;
      end
      else if (i_sfr.addr == ADDR_SPEED_MODE)
      begin
        nxt_st.rdata = {3'h0, st_ff.itmr_clk, 4'h0};
      end
      else if (i_sfr.addr == ADDR_CLK_SEL)
      begin
        nxt_st.rdata = {2'h0, st_ff.src_stat, st_ff.src_req, 4'h0};
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
      st_ff.freq_code <= RST_FREQ_CODE;
      st_ff.freq_pend <= RST_FREQ_CODE;
      st_ff.rst_hold <= 1'b1;
      st_ff.fast_run <= 1'b1;
      st_ff.xtal_stop <= 1'b1;
      st_ff.pin_input <= 1'b1;
      st_ff.stab_sel <= RST_STAB_SEL;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_sfr_rdata = st_ff.rdata;
  assign o_crystal_run = st_ff.xtal_run;
  assign o_crystal_gain_high = st_ff.gain_high;
  assign o_ext_clk_enable = st_ff.ext_en;
  assign o_xpin_input_mode = st_ff.pin_input;
  assign o_fast_osc_run = st_ff.fast_run;
  assign o_fast_osc_code = st_ff.freq_code;
  assign o_slow_osc_run = st_ff.slow_run;
  assign o_main_src_sel = st_ff.src_stat;
  assign o_clk_hold = st_ff.clk_hold;
  assign o_cpu_reset_hold = st_ff.rst_hold;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ast_cyc <= 13'h0000;
    end
    else if (ast_cyc != 13'h1FFF)
    begin
      ast_cyc <= ast_cyc + 13'h0001;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_freq_wr;
    (st_ff.fstate == FS_IDLE) && wr_ok && (i_sfr.addr == ADDR_FREQ_SEL)
      && freq_code_ok(i_sfr.wdata[2:0]);
  endsequence

  sequence s_freq_old;
    ($stable(o_fast_osc_code) && !o_clk_hold) [*3];
  endsequence

  sequence s_freq_held;
    o_clk_hold [*3] ##1 !o_clk_hold;
  endsequence

  sequence s_src_wr;
    wr_ok && (i_sfr.addr == ADDR_CLK_SEL) && (i_sfr.wdata[BIT_SRC_SEL] != o_main_src_sel);
  endsequence

  AST_FREQ_STEPS: assert property (s_freq_wr |=> s_freq_old ##1 s_freq_held)
    else $error("retune did not run three old then three held cycles");
  AST_FREQ_APPLY: assert property (s_freq_wr |-> ##4 o_fast_osc_code == $past(i_sfr.wdata[2:0], 4))
    else $error("fast oscillator code differs from the written value");
  AST_BAD_CODE: assert property ((st_ff.fstate == FS_IDLE) && wr_ok
      && (i_sfr.addr == ADDR_FREQ_SEL) && !freq_code_ok(i_sfr.wdata[2:0])
      |=> $stable(o_fast_osc_code) && (st_ff.fstate == FS_IDLE))
    else $error("prohibited code disturbed the fast oscillator");
  AST_SLOW_ON: assert property (i_watchdog_run |=> o_slow_osc_run)
    else $error("slow oscillator off while the watchdog runs");
  AST_SLOW_OFF: assert property ((!i_watchdog_run && !st_ff.itmr_clk) [*2] |-> !o_slow_osc_run)
    else $error("slow oscillator on with no user");
  AST_RESET_SRC: assert property (o_cpu_reset_hold |-> !o_main_src_sel && o_fast_osc_run)
    else $error("main clock not on the fast oscillator after reset");
  AST_RESET_HOLD: assert property ($fell(o_cpu_reset_hold) |-> ast_cyc >= 13'(HOCO_SETTLE_CYC))
    else $error("reset processing ended before oscillator settling");
  AST_MODE_ONCE: assert property (st_ff.mode_locked && wr_ok && (i_sfr.addr == ADDR_OSC_MODE)
      |=> $stable({st_ff.ext_sel, st_ff.osc_sel, st_ff.gain_high}))
    else $error("oscillator mode register took a second write");
  AST_SRC_STABLE: assert property (s_src_wr |=> $stable(o_main_src_sel) [*5])
    else $error("source switched too soon after the select write");
  AST_SRC_READY: assert property ($changed(o_main_src_sel)
      |-> $past((st_ff.sstate == SS_COUNT) && src_ready))
    else $error("source switched to a clock that was not running");
  AST_FAST_STOP: assert property (wr_ok && (i_sfr.addr == ADDR_RUN_CTRL)
      |=> o_fast_osc_run == !$past(i_sfr.wdata[BIT_FAST_STOP]))
    else $error("fast oscillator run state does not follow its stop bit");
  AST_EXT_MODE: assert property (st_ff.osc_sel && st_ff.ext_sel && !st_ff.xtal_stop
      |-> o_ext_clk_enable && !o_crystal_run && !o_xpin_input_mode)
    else $error("external clock mode decoded wrongly");
endmodule : scg_clock_gen
`default_nettype wire

/* scg_pkg.sv */
`default_nettype none
package scg_pkg;
  localparam logic [19:0] ADDR_BOOT_OPT = 20'h000C2;
  localparam logic [19:0] ADDR_FREQ_SEL = 20'hF00A8;
  localparam logic [19:0] ADDR_SPEED_MODE = 20'hF00F3;
  localparam logic [19:0] ADDR_OSC_MODE = 20'hF00A0;
  localparam logic [19:0] ADDR_RUN_CTRL = 20'hF00A1;
  localparam logic [19:0] ADDR_STAB_SEL = 20'hF00A2;
  localparam logic [19:0] ADDR_STAB_STAT = 20'hF00A3;
  localparam logic [19:0] ADDR_CLK_SEL = 20'hF00A4;
  localparam int BIT_FAST_STOP = 0;
  localparam int BIT_XTAL_STOP = 7;
  localparam int BIT_ITMR_CLK = 4;
  localparam int BIT_SRC_SEL = 4;
  localparam int BIT_EXT_SEL = 7;
  localparam int BIT_OSC_SEL = 6;
  localparam int BIT_GAIN = 0;
  localparam logic [2:0] RST_FREQ_CODE = 3'h1;
  localparam logic [2:0] RST_STAB_SEL = 3'h7;
  localparam logic [2:0] FREQ_CODE_MIN = 3'h1;
  localparam logic [2:0] FREQ_CODE_MAX = 3'h5;
  localparam logic [2:0] STAB_SEL_MAX = 3'h7;
  localparam int STAB_EXP [8] = '{8, 9, 10, 11, 13, 15, 17, 18};
  localparam int FREQ_OLD_CYC = 3;
  localparam int FREQ_WAIT_CYC = 3;
  localparam int SRC_SWITCH_CYC = 4;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int HOCO_SETTLE_NS = 27000;
  localparam int HOCO_SETTLE_CYC_I = (HOCO_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] HOCO_SETTLE_CYC = 12'(HOCO_SETTLE_CYC_I);

  typedef enum logic [1:0] {FS_IDLE, FS_OLD, FS_WAIT} scg_freq_state_t;
  typedef enum logic [1:0] {SS_IDLE, SS_WAIT, SS_COUNT} scg_src_state_t;

  typedef struct packed {
    logic [19:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } scg_sfr_req_t;

  typedef struct packed {
    logic [2:0] freq_code;
    logic [2:0] freq_pend;
    scg_freq_state_t fstate;
    logic [1:0] fcnt;
    logic clk_hold;
    logic boot_loaded;
    logic rst_hold;
    logic [11:0] rst_cnt;
    logic ext_sel;
    logic osc_sel;
    logic gain_high;
    logic mode_locked;
    logic xtal_stop;
    logic fast_run;
    logic xtal_run;
    logic ext_en;
    logic pin_input;
    logic [2:0] stab_sel;
    logic after_stop;
    logic itmr_clk;
    logic slow_run;
    logic src_req;
    logic src_stat;
    scg_src_state_t sstate;
    logic [1:0] scnt;
    logic [7:0] rdata;
  } scg_state_t;

  typedef struct packed {
    logic [18:0] cnt;
    logic [7:0] stat;
    logic done;
  } scg_stab_t;

  function automatic logic freq_code_ok(input logic [2:0] code);
    return (code >= FREQ_CODE_MIN) && (code <= FREQ_CODE_MAX);
  endfunction : freq_code_ok
endpackage : scg_pkg
`default_nettype wire

/* scg_stab_counter.sv */
`default_nettype none
module scg_stab_counter
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Crystal activity
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic i_tick,
  input wire logic [2:0] i_limit,
  // Status
  output logic [7:0] o_status,
  output logic o_done
);
  import scg_pkg::*;

  scg_stab_t st_ff;
  scg_stab_t nxt_st;
  logic [7:0] reach;
  logic [18:0] target;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_tap
      assign reach[7 - gi] = st_ff.cnt >= (19'h00001 << STAB_EXP[gi]);
    end
  endgenerate

  assign target = 19'h00001 << STAB_EXP[i_limit];

  always_comb
  begin
    nxt_st = st_ff;
    // The count saturates at the selected wait so later taps stay clear.
    if (!i_run || i_restart)
    begin
      nxt_st.cnt = '0;
    end
    else if (i_tick && (st_ff.cnt < target))
    begin
      nxt_st.cnt = st_ff.cnt + 19'h00001;
    end
    nxt_st.stat = reach;
    nxt_st.done = reach[3'h7 - i_limit];
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_status = st_ff.stat;
  assign o_done = st_ff.done;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  AST_STAT_ORDER: assert property ((o_status[6:0] & ~o_status[7:1]) == 7'h00)
    else $error("stabilization status not filled from the top bit");
  AST_STAB_CLEAR: assert property (!i_run |-> ##2 o_status == 8'h00)
    else $error("stabilization status kept while crystal stopped");
  AST_STAB_DONE: assert property ($rose(o_done) |-> o_status[3'h7 - $past(i_limit)])
    else $error("stabilization done before the selected wait");
endmodule : scg_stab_counter
`default_nettype wire

/* scg_xtal_model.sv */
`default_nettype none
module scg_xtal_model
(
  // Clock
  input wire logic i_clk_sys,
  // Pin enables from the generator, and the slow-tick select from the bench
  input wire logic i_run,
  input wire logic i_ext,
  input wire logic i_slow,
  // Tick towards the generator
  output logic o_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_ff;
  initial
  begin
    ph_ff = 1'b0;
    o_tick = 1'b0;
  end
  // The source stands still while neither pin mode is enabled, so a stray tick
  // can never fake stabilization progress.
  always @(posedge i_clk_sys)
  begin
    ph_ff <= (i_run | i_ext) ? ~ph_ff : 1'b0;
    o_tick <= (i_run | i_ext) & (~i_slow | ph_ff);
  end
endmodule : scg_xtal_model
`default_nettype wire

/* tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scg_pkg::*;
  logic i_clk_sys, i_rst_n, i_watchdog_run, i_stop_exit, i_crystal_tick, slow_tick;
  scg_sfr_req_t i_sfr;
  logic [7:0] i_option_byte, o_sfr_rdata, v;
  logic xr, xg, xe, xp, fr, sl, src, hold, crh;
  logic [2:0] code;
  logic [31:0] rs, a;
  int bad_count, tests_run, cyc, n, m_freq, old;
  bit ok;

  scg_clock_gen dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sfr(i_sfr),
    .o_sfr_rdata(o_sfr_rdata), .i_option_byte(i_option_byte),
    .i_watchdog_run(i_watchdog_run), .i_stop_exit(i_stop_exit),
    .i_crystal_tick(i_crystal_tick), .o_crystal_run(xr), .o_crystal_gain_high(xg),
    .o_ext_clk_enable(xe), .o_xpin_input_mode(xp), .o_fast_osc_run(fr),
    .o_fast_osc_code(code), .o_slow_osc_run(sl), .o_main_src_sel(src),
    .o_clk_hold(hold), .o_cpu_reset_hold(crh));

  scg_xtal_model xtal_u (.i_clk_sys(i_clk_sys), .i_run(xr), .i_ext(xe),
    .i_slow(slow_tick), .o_tick(i_crystal_tick));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask : chk1

  task automatic wr(input logic [19:0] ad, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_sfr = '{addr: ad, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge i_clk_sys);
    i_sfr.wr = 1'b0;
  endtask : wr

  // Read data stands for one cycle only, so it is taken at the next falling edge.
  task automatic rd(input logic [19:0] ad);
    @(negedge i_clk_sys);
    i_sfr = '{addr: ad, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge i_clk_sys);
    i_sfr.rd = 1'b0;
    v = o_sfr_rdata;
  endtask : rd

  task automatic wait_src();
    n = 0;
    while (src !== 1'b1 && n < 40)
    begin
      @(negedge i_clk_sys);
      n++;
    end
  endtask : wait_src

  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (20) @(negedge i_clk_sys);
    chk1(src, 1'b0);
    chk1(xr, 1'b0);
    chk1(xp, 1'b1);
    chk1(fr, 1'b1);
    chk1(crh, 1'b1);
    m_freq = 1 + int'(rnd() % 5);
    i_option_byte = {5'h1F, 3'(m_freq)};
    i_rst_n = 1'b1;
    n = 0;
    do
    begin
      @(negedge i_clk_sys);
      n++;
    end
    while (crh === 1'b1 && n < 5000);
    chk1(n == HOCO_SETTLE_CYC_I + 1, 1'b1);
    chk8({5'h00, code}, 8'(m_freq));
  endtask : do_reset

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  initial
  begin
    i_rst_n = 1'b0;
    i_sfr = '0;
    i_option_byte = 8'hFB;
    i_watchdog_run = 1'b0;
    i_stop_exit = 1'b0;
    rs = 32'hA0AD98F9;
    slow_tick = rnd() % 2;
    do_reset();
    // Retuning happens while the fast oscillator drives the clock.
    for (int c = 0; c < 8; c++)
    begin
      old = m_freq;
      ok = (c >= 1) && (c <= 5);
      a = rnd();
      wr(ADDR_FREQ_SEL, {a[7:3], 3'(c)});
      for (int k = 1; k < 8; k++)
      begin
        @(negedge i_clk_sys);
        // The third edge after the write both applies the new code and starts the hold.
        chk8({5'h00, code}, (ok && k > 2) ? 8'(c) : 8'(old));
        chk1(hold, ok && k > 2 && k < 6);
      end
      if (ok)
        m_freq = c;
      rd(ADDR_FREQ_SEL);
      chk8(v, 8'(m_freq));
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_SPEED_MODE, {3'h0, k[0], 4'h0});
      i_watchdog_run = k[1];
      repeat (3) @(negedge i_clk_sys);
      chk1(sl, k[0] | k[1]);
    end
    rd(20'hF00AF);
    chk8(v, 8'h00);
    wr(ADDR_OSC_MODE, 8'h41);
    wr(ADDR_OSC_MODE, 8'hC0);
    rd(ADDR_OSC_MODE);
    chk8(v, 8'h41);
    chk1(xg, 1'b1);
    wr(ADDR_STAB_SEL, 8'h02);
    rd(ADDR_STAB_STAT);
    chk8(v, 8'h00);
    wr(ADDR_RUN_CTRL, 8'h00);
    repeat (2) @(negedge i_clk_sys);
    chk1(xr, 1'b1);
    chk1(xp, 1'b0);
    i_stop_exit = 1'b1;
    @(negedge i_clk_sys);
    i_stop_exit = 1'b0;
    n = 0;
    do
    begin
      rd(ADDR_STAB_STAT);
      n++;
    end
    while (v[5] !== 1'b1 && n < 3000);
    chk8(v, 8'hE0);
    // Only now is the crystal stable enough to carry the main clock.
    wr(ADDR_CLK_SEL, 8'h10);
    repeat (5)
    begin
      @(negedge i_clk_sys);
      chk1(src, 1'b0);
    end
    // With the crystal already stable the switch lands on the sixth edge exactly.
    @(negedge i_clk_sys);
    chk1(src, 1'b1);
    wait_src();
    chk1(src, 1'b1);
    rd(ADDR_CLK_SEL);
    chk8(v, 8'h30);
    wr(ADDR_RUN_CTRL, 8'h01);
    repeat (2) @(negedge i_clk_sys);
    chk1(fr, 1'b0);
    do_reset();
    wr(ADDR_OSC_MODE, 8'hC0);
    wr(ADDR_RUN_CTRL, 8'h00);
    repeat (2) @(negedge i_clk_sys);
    chk1(xe, 1'b1);
    wr(ADDR_CLK_SEL, 8'h10);
    wait_src();
    chk1(src, 1'b1);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
